// file: core/mcu_parallel_bus_interface.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Address strobe latches multiplexed address
// - Latched address shown on port A/B
// - Drive data port only on internal read
// - Muxed mode: extra high address from ports
// - Non-muxed: address on data port, data on A
// - Non-muxed: port A undriven when idle
// - Non-muxed: extra address from ports B-D
// - Address bit zero picks even/odd byte
// - Unused control input feeds logic array
// - Three configurable strobe schemes supported
// - Fetch strobe alone reads on input 1
// - Read or fetch strobe both read
// - Fetch, read, write reach internal resources
// - Page hit reuses latched high address
// - Burst keeps upper address, low changes
module mcu_parallel_bus_interface
	import bus_if_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire scheme_t scheme,
	input wire logic muxed_mode,
	input wire logic use_addr_strobe,
	input wire logic page_mode,
	input wire logic addr_out_on_b,
	input wire logic [1:0] xaddr_port_sel,
	input wire logic control_in_0,
	input wire logic control_in_1,
	input wire logic control_in_2,
	input wire logic strobe_pin,
	input wire logic high_byte_enable,
	input wire logic [DATA_W-1:0] addr_data_port_in,
	output logic [DATA_W-1:0] addr_data_port_out,
	output logic addr_data_port_oe,
	input wire logic [DATA_W-1:0] port_a_in,
	input wire logic [DATA_W-1:0] port_b_in,
	input wire logic [DATA_W-1:0] port_c_in,
	input wire logic [DATA_W-1:0] port_d_in,
	output logic [DATA_W-1:0] port_a_out,
	output logic port_a_oe,
	output logic [DATA_W-1:0] port_b_out,
	output logic port_b_oe,
	input wire logic [ADDR_W-1:0] hi_addr_in,
	input wire logic resource_hit,
	input wire logic [DATA_W-1:0] rd_data,
	output logic [ADDR_W-1:0] acc_addr,
	output logic [XADDR_W-1:0] acc_xaddr,
	output logic acc_odd_byte,
	output logic [DATA_W-1:0] wr_data,
	output logic wr_pulse,
	output logic rd_active,
	output logic array_in
);
	logic [ADDR_W-1:0] full_addr;
	logic [ADDR_W-1:0] lat_addr;
	logic rd_req;
	logic wr_req;
	logic [XADDR_W-1:0] xsrc;
	acc_state_t st_q, st_d;
	logic [DATA_W-1:0] ado_q, ado_d, pa_q, pa_d, pb_q, pb_d, wd_q, wd_d;
	logic adoe_q, adoe_d, paoe_q, paoe_d, pboe_q, pboe_d, wp_q, wp_d;
	logic [ADDR_W-1:0] aa_q, aa_d, acc_src;
	logic [XADDR_W-1:0] xa_q, xa_d;
	logic odd_q, odd_d, ai_q, ai_d, rda_q, rda_d;

	// page mode: high byte on data port
	always_comb begin
		full_addr = {hi_addr_in[ADDR_W-1:DATA_W], addr_data_port_in};
		if (muxed_mode && page_mode) begin
			full_addr = {addr_data_port_in, port_a_in};
		end
	end

	addr_latch #(.W(ADDR_W)) u_latch (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.use_strobe(use_addr_strobe & muxed_mode),
		.strobe(strobe_pin),
		.addr_in(full_addr),
		.addr_out(lat_addr)
	);
	// page hit: held high byte, live low byte
	assign acc_src = (muxed_mode && page_mode) ?
		{lat_addr[ADDR_W-1:DATA_W], port_a_in} : lat_addr;

	always_comb begin
		unique case (scheme)
			SCHEME_WR_RD_PROGRAM_FETCH_STROBE: begin
				rd_req = !control_in_1 || !control_in_2;
				wr_req = !control_in_0;
			end
			SCHEME_WR_FETCH: begin
				rd_req = !control_in_1;
				wr_req = !control_in_0;
			end
			SCHEME_RW_EN: begin
				rd_req = control_in_1 && control_in_0;
				wr_req = control_in_1 && !control_in_0;
			end
			default: begin
				rd_req = 1'b0;
				wr_req = 1'b0;
			end
		endcase
	end

	always_comb begin
		unique case (xaddr_port_sel)
			2'h0: xsrc = muxed_mode ? port_a_in : port_b_in;
			2'h1: xsrc = port_b_in;
			2'h2: xsrc = port_c_in;
			default: xsrc = port_d_in;
		endcase
	end

	always_comb begin
		st_d = st_q;
		wp_d = 1'b0;
		wd_d = wd_q;
		aa_d = aa_q;
		xa_d = xa_q;
		odd_d = odd_q;
		ado_d = ado_q;
		adoe_d = 1'b0;
		pa_d = pa_q;
		paoe_d = 1'b0;
		ai_d = (scheme == SCHEME_WR_RD_PROGRAM_FETCH_STROBE) ? ai_q : control_in_2;
		pb_d = addr_out_on_b ? lat_addr[DATA_W-1:0] : pb_q;
		pboe_d = addr_out_on_b;
		if (!addr_out_on_b && muxed_mode && !page_mode) begin
			pa_d = lat_addr[DATA_W-1:0];
			paoe_d = 1'b1;
		end
		if (rd_req || wr_req) begin
			aa_d = acc_src;
			xa_d = xsrc;
			odd_d = acc_src[0];
		end
		unique case (st_q)
			ST_IDLE: begin
				if (rd_req) begin
					st_d = ST_READ;
				end else if (wr_req) begin
					st_d = ST_WRITE;
				end
			end
			ST_READ: begin
				if (!rd_req) begin
					st_d = ST_IDLE;
				end
			end
			ST_WRITE: begin
				wd_d = muxed_mode ? addr_data_port_in : port_a_in;
				if (!wr_req) begin
					wp_d = 1'b1;
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		rda_d = (st_d == ST_READ);
		if (rd_req && resource_hit) begin
			if (muxed_mode) begin
				ado_d = rd_data;
				adoe_d = 1'b1;
			end else begin
				pa_d = rd_data;
				paoe_d = 1'b1;
			end
		end
		if (!muxed_mode && !(rd_req && resource_hit)) begin
			paoe_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= ST_IDLE;
			wp_q <= 1'b0;
			wd_q <= DATA_RST;
			aa_q <= ADDR_RST;
			xa_q <= XADDR_RST;
			odd_q <= 1'b0;
			ado_q <= DATA_RST;
			adoe_q <= 1'b0;
			pa_q <= DATA_RST;
			paoe_q <= 1'b0;
			pb_q <= DATA_RST;
			pboe_q <= 1'b0;
			ai_q <= 1'b0;
			rda_q <= 1'b0;
		end else begin
			st_q <= st_d;
			wp_q <= wp_d;
			wd_q <= wd_d;
			aa_q <= aa_d;
			xa_q <= xa_d;
			odd_q <= odd_d;
			ado_q <= ado_d;
			adoe_q <= adoe_d;
			pa_q <= pa_d;
			paoe_q <= paoe_d;
			pb_q <= pb_d;
			pboe_q <= pboe_d;
			ai_q <= ai_d;
			rda_q <= rda_d;
		end
	end

	assign addr_data_port_out = ado_q;
	assign addr_data_port_oe = adoe_q;
	assign port_a_out = pa_q;
	assign port_a_oe = paoe_q;
	assign port_b_out = pb_q;
	assign port_b_oe = pboe_q;
	assign acc_addr = aa_q;
	assign acc_xaddr = xa_q;
	assign acc_odd_byte = odd_q;
	assign wr_data = wd_q;
	assign wr_pulse = wp_q;
	assign rd_active = rda_q;
	assign array_in = ai_q;

	property p_drive_on_read;
		@(posedge ref_clk) disable iff (!resetn)
		addr_data_port_oe |-> $past(rd_req && resource_hit && muxed_mode);
	endproperty
	a_drive_on_read: assert property (p_drive_on_read) else $error("data port driven without read");
	property p_pa_idle;
		@(posedge ref_clk) disable iff (!resetn)
		(!muxed_mode && !(rd_req && resource_hit)) |=> !port_a_oe;
	endproperty
	a_pa_idle: assert property (p_pa_idle) else $error("port A driven while idle");
	property p_wr_end;
		@(posedge ref_clk) disable iff (!resetn)
		wr_pulse |-> $past(st_q == ST_WRITE) && $past(!wr_req);
	endproperty
	a_wr_end: assert property (p_wr_end) else $error("write pulse without strobe end");
	property p_odd;
		@(posedge ref_clk) disable iff (!resetn)
		(rd_req || wr_req) |=> acc_odd_byte == $past(acc_src[0]);
	endproperty
	a_odd: assert property (p_odd) else $error("byte select mismatch");
	property p_rw;
		@(posedge ref_clk) disable iff (!resetn)
		(scheme == SCHEME_RW_EN && !control_in_0 && st_q == ST_IDLE) |=> st_q != ST_READ;
	endproperty
	a_rw: assert property (p_rw) else $error("read on write select");
	property p_fetch;
		@(posedge ref_clk) disable iff (!resetn)
		(scheme == SCHEME_WR_RD_PROGRAM_FETCH_STROBE && !control_in_2 && resource_hit && muxed_mode)
			|=> addr_data_port_oe;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch not treated as read");

	property p_addr_b;
		@(posedge ref_clk) disable iff (!resetn)
		addr_out_on_b |=> port_b_oe && port_b_out == $past(lat_addr[DATA_W-1:0]);
	endproperty
	a_addr_b: assert property (p_addr_b) else $error("latched address not on port B");

	property p_single_rd;
		@(posedge ref_clk) disable iff (!resetn)
		(scheme == SCHEME_WR_FETCH && control_in_1 && st_q == ST_IDLE) |=> st_q != ST_READ;
	endproperty
	a_single_rd: assert property (p_single_rd) else $error("read without fetch strobe");

	c_read: cover property (@(posedge ref_clk) disable iff (!resetn) addr_data_port_oe);
	c_write: cover property (@(posedge ref_clk) disable iff (!resetn) wr_pulse);
	c_nonmux: cover property (@(posedge ref_clk) disable iff (!resetn) !muxed_mode && port_a_oe);
endmodule

// file: core/bus_if_pkg.sv
package bus_if_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int XADDR_W = 8;
	// Bus scheme selected by configuration
	typedef enum logic [1:0] {
		SCHEME_WR_RD_PROGRAM_FETCH_STROBE = 2'b00,
		SCHEME_WR_FETCH = 2'b01,
		SCHEME_RW_EN = 2'b11
	} scheme_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_WRITE = 2'b11
	} acc_state_t;
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [XADDR_W-1:0] XADDR_RST = 8'h00;
endpackage

// file: core/addr_latch.sv
`timescale 1ns/100ps
// Address capture on strobe; transparent when no strobe is used
module addr_latch
	import bus_if_pkg::*;
#(
	parameter int W = ADDR_W
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic use_strobe,
	input wire logic strobe,
	input wire logic [W-1:0] addr_in,
	output logic [W-1:0] addr_out
);
	logic [W-1:0] lat_q;
	logic [W-1:0] lat_d;

	always_comb begin
		lat_d = lat_q;
		if (strobe) begin
			lat_d = addr_in;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			lat_q <= '0;
		end else begin
			lat_q <= lat_d;
		end
	end

	assign addr_out = use_strobe ? lat_q : addr_in;
endmodule

// file: sim/mcu_host_model.sv
`timescale 1ns/100ps
module mcu_host_model
	import bus_if_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [DATA_W-1:0] addr_data_port_out,
	input wire logic addr_data_port_oe,
	output logic [DATA_W-1:0] addr_data_port_in,
	output logic control_in_0,
	output logic control_in_1,
	output logic control_in_2,
	output logic strobe_pin
);
	logic [DATA_W-1:0] drv_q = 8'h00;
	logic [DATA_W-1:0] last_q = 8'h00;
	logic own_q = 1'b0;
	// Released bus shows a toggling pattern
	assign addr_data_port_in = addr_data_port_oe ? addr_data_port_out : (own_q ? drv_q : ~last_q);
	always @(posedge ref_clk) begin
		last_q <= addr_data_port_in;
	end
	initial begin
		{control_in_2, control_in_1, control_in_0} = 3'h7;
		strobe_pin = 1'b0;
	end
	task automatic addr_phase(input logic [DATA_W-1:0] a);
		@(negedge ref_clk);
		strobe_pin = 1'b1;
		own_q = 1'b1;
		drv_q = a;
		@(negedge ref_clk);
		strobe_pin = 1'b0;
		own_q = 1'b0;
	endtask
	// non-muxed host drives address, no strobe
	task automatic hold_addr(input logic hold, input logic [DATA_W-1:0] a);
		@(negedge ref_clk);
		own_q = hold;
		drv_q = a;
	endtask
	task automatic set_ctl(input logic [2:0] c);
		@(negedge ref_clk);
		{control_in_2, control_in_1, control_in_0} = c;
	endtask
	task automatic wr(input logic [DATA_W-1:0] d, input logic [2:0] act, input logic [2:0] idle);
		set_ctl(act);
		own_q = 1'b1;
		drv_q = d;
		@(negedge ref_clk);
		set_ctl(idle);
		@(negedge ref_clk);
		own_q = 1'b0;
	endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import bus_if_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	scheme_t scheme = SCHEME_WR_RD_PROGRAM_FETCH_STROBE;
	logic muxed_mode = 1'b1, use_addr_strobe = 1'b1, page_mode = 1'b0, addr_out_on_b = 1'b0;
	logic high_byte_enable = 1'b0, resource_hit = 1'b0, r;
	logic [1:0] xaddr_port_sel = 2'h1;
	logic [DATA_W-1:0] port_a_in = 8'h00, port_b_in = 8'h00;
	logic [DATA_W-1:0] port_c_in = 8'h00, port_d_in = 8'h00, rd_data = 8'h00, lo, hi;
	logic [DATA_W-1:0] addr_data_port_in, addr_data_port_out, port_a_out, port_b_out, wr_data;
	logic [ADDR_W-1:0] hi_addr_in = 16'h0000, acc_addr;
	logic [XADDR_W-1:0] acc_xaddr;
	logic addr_data_port_oe, port_a_oe, port_b_oe, acc_odd_byte, wr_pulse, rd_active, array_in;
	logic control_in_0, control_in_1, control_in_2, strobe_pin;
	logic [2:0] ract, ridle;
	logic [31:0] v, w;
	integer seed = 32'he67f;
	int error_cnt = 0, comparisons = 0;

	mcu_parallel_bus_interface uut (.ref_clk, .resetn, .scheme, .muxed_mode, .use_addr_strobe,
		.page_mode, .addr_out_on_b, .xaddr_port_sel, .control_in_0, .control_in_1,
		.control_in_2, .strobe_pin, .high_byte_enable, .addr_data_port_in,
		.addr_data_port_out, .addr_data_port_oe, .port_a_in, .port_b_in, .port_c_in,
		.port_d_in, .port_a_out, .port_a_oe, .port_b_out, .port_b_oe, .hi_addr_in,
		.resource_hit, .rd_data, .acc_addr, .acc_xaddr, .acc_odd_byte, .wr_data, .wr_pulse,
		.rd_active, .array_in);
	mcu_host_model host (.ref_clk, .addr_data_port_out, .addr_data_port_oe,
		.addr_data_port_in, .control_in_0, .control_in_1, .control_in_2, .strobe_pin);

	always #20 ref_clk = ~ref_clk;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	function automatic logic [7:0] exp_x(input logic [1:0] s);
		return s == 2'h0 ? port_a_in :
			(s == 2'h1 ? port_b_in : (s == 2'h2 ? port_c_in : port_d_in));
	endfunction

	// Read strobe, answer a cycle later, release
	task automatic rd_chk(input logic [2:0] act, input logic [2:0] idle, input logic [15:0] a);
		host.set_ctl(act);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(addr_data_port_oe, resource_hit);
		if (resource_hit) chk(addr_data_port_out, rd_data);
		if (resource_hit) chk(rd_active, 1'b1);
		chk(acc_addr, a);
		chk(acc_odd_byte, a[0]);
		if (scheme != SCHEME_WR_RD_PROGRAM_FETCH_STROBE) chk(array_in, act[2]);
		host.set_ctl(idle);
		@(posedge ref_clk);
		#1;
		chk(addr_data_port_oe, 1'b0);
	endtask

	initial begin
		#1000000;
		error_cnt++;
		finish_test();
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		#1;
		chk(addr_data_port_oe, 1'b0);
		chk(port_a_oe, 1'b0);
		repeat (11) @(negedge ref_clk);
		resetn = 1'b1;
		for (int i = 0; i < 200; i++) begin
			@(negedge ref_clk);
			v = $random(seed);
			w = $random(seed);
			r = v[26] | ~v[25];
			{rd_data, hi, lo} = v[23:0];
			{port_d_in, port_c_in, port_b_in, port_a_in} = w;
			hi_addr_in = {hi, ~lo};
			resource_hit = v[28:27] != 2'h0;
			addr_out_on_b = v[29];
			high_byte_enable = v[30];
			xaddr_port_sel = {v[31], ~v[29]};
			case (v[25:24])
				2'h0: ract = 3'h5;
				2'h1: ract = 3'h3;
				2'h2: ract = {r, 2'h1};
				default: ract = {r, 2'h3};
			endcase
			ridle = v[25:24] == 2'h3 ? {r, 2'h1} : {r, 2'h3};
			host.set_ctl(ridle);
			scheme = v[25] ? (v[24] ? SCHEME_RW_EN : SCHEME_WR_FETCH) : SCHEME_WR_RD_PROGRAM_FETCH_STROBE;
			host.addr_phase(lo);
			rd_chk(ract, ridle, {hi, lo});
			chk(addr_out_on_b ? port_b_out : port_a_out, lo);
			chk(addr_out_on_b ? port_b_oe : port_a_oe, 1'b1);
			chk(acc_xaddr, exp_x(xaddr_port_sel));
			@(negedge ref_clk);
			resource_hit = 1'b1;
			host.wr(lo ^ hi, {r, 2'h2}, v[25:24] == 2'h3 ? {r, 2'h0} : {r, 2'h3});
			chk(wr_pulse, 1'b1);
			chk(wr_data, lo ^ hi);
			@(posedge ref_clk);
			#1;
			chk(wr_pulse, 1'b0);
		end
		host.set_ctl(3'h7);
		scheme = SCHEME_WR_RD_PROGRAM_FETCH_STROBE;
		page_mode = 1'b1;
		port_a_in = 8'h3c;
		host.addr_phase(8'hc5);
		rd_chk(3'h5, 3'h7, 16'hc53c);
		@(negedge ref_clk);
		port_a_in = 8'h3d;
		rd_chk(3'h5, 3'h7, 16'hc53d);
		@(negedge ref_clk);
		page_mode = 1'b0;
		muxed_mode = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		chk(port_a_oe, 1'b0);
		host.hold_addr(1'b1, 8'h5a);
		hi_addr_in = 16'ha700;
		rd_data = 8'h96;
		port_b_in = 8'h4e;
		xaddr_port_sel = 2'h0;
		host.set_ctl(3'h5);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(port_a_oe, 1'b1);
		chk(port_a_out, 8'h96);
		chk(addr_data_port_oe, 1'b0);
		chk(acc_addr, 16'ha75a);
		chk(acc_xaddr, 8'h4e);
		host.set_ctl(3'h7);
		@(posedge ref_clk);
		#1;
		chk(port_a_oe, 1'b0);
		@(negedge ref_clk);
		port_a_in = 8'h69;
		host.wr(8'h5a, 3'h6, 3'h7);
		chk(wr_pulse, 1'b1);
		chk(wr_data, 8'h69);
		finish_test();
	end
endmodule
